// ### inc/umfc_params.svh
// constants of the serial mode and frame control block
`ifndef UMFC_PARAMS_SVH
`define UMFC_PARAMS_SVH
// register indices as printed; byte address is four times the index
`define UMFC_IDX_STATUS     8'h04
`define UMFC_IDX_LINE_CTRL  8'h05
`define UMFC_IDX_RX_TX_CTRL 8'h06
`define UMFC_IDX_FRAME_CTRL 8'h07
`define UMFC_ADDR_W         8
// reset values
`define UMFC_RST_RX_TX      8'h00
`define UMFC_RST_FRAME      8'h03
`define UMFC_RST_SPI        8'h00
`define UMFC_RST_LINE       8'h00
// rx_tx_control bit positions
`define UMFC_B_RX_ON        7
`define UMFC_B_TX_ON        6
`define UMFC_B_SFD_ON       4
`define UMFC_B_OD_SEL       3
`define UMFC_B_RECEIVE_SPEED_MODE_HI    2
`define UMFC_B_RECEIVE_SPEED_MODE_LO    1
`define UMFC_B_MULTIPROCESSOR_FILTER         0
// frame_format_control bit positions
`define UMFC_B_COMMUNICATION_MODE_HI     7
`define UMFC_B_COMMUNICATION_MODE_LO     6
`define UMFC_B_PAR_HI       5
`define UMFC_B_PAR_LO       4
`define UMFC_B_STOP         3
`define UMFC_B_ORDER        2
`define UMFC_B_PHASE        1
// baud divisors and sync checks
`define UMFC_DIV_NORMAL     5'd16
`define UMFC_DIV_DOUBLE     5'd8
`define UMFC_PAIR_NOM       8'd32
`define UMFC_PAIR_TOL       8'd6
`define UMFC_SYNC_CHAR      8'h55
`endif

// ### inc/umfc_pkg.sv
// types of the serial mode and frame control block
package umfc_pkg;
   typedef enum logic [1:0] {
      UMFC_LD_OFF = 2'h0, UMFC_LD_EXT = 2'h1, UMFC_LD_INT = 2'h2, UMFC_LD_RSV = 2'h3
   } umfc_ld_t;
   typedef enum logic [1:0] {
      UMFC_RX_NORMAL = 2'h0, UMFC_RX_DOUBLE = 2'h1, UMFC_RX_GENAB = 2'h2, UMFC_RX_CONAB = 2'h3
   } umfc_rxm_t;
   typedef enum logic [1:0] {
      UMFC_CM_ASYNC = 2'h0, UMFC_CM_SYNC = 2'h1, UMFC_CM_IR = 2'h2, UMFC_CM_SPI = 2'h3
   } umfc_cm_t;
   typedef enum logic [1:0] {
      UMFC_PAR_OFF = 2'h0, UMFC_PAR_RSV = 2'h1, UMFC_PAR_EVEN = 2'h2, UMFC_PAR_ODD = 2'h3
   } umfc_par_t;
   // decoded setup handed to the shift engines
   typedef struct packed {
      umfc_cm_t   mode;
      umfc_par_t  parity;
      logic [1:0] stop_bits;
      logic [3:0] data_bits;
      logic       nine_low_first;
      logic       lsb_first;
      logic       sample_trailing;
      logic [4:0] baud_div;
      logic       rx_enabled;
      logic       tx_enabled;
   } umfc_cfg_t;
   // one finished receive frame
   typedef struct packed {
      logic       done;
      logic [8:0] data;
      logic       parity_bit;
      logic       stop_ok;
      logic       is_address;
      logic       overrun;
   } umfc_rxf_t;
endpackage : umfc_pkg

// ### design/umfc_ctrl.sv
// serial mode and frame control with its register slave
//
// Behaviour
// - line driver mode: off, external, internal, reserved
// - receiver on takes over receive pin
// - receiver off flushes buffer and error flags
// - receiver off resets autobaud in autobaud modes
// - transmitter runs until shifter and buffer empty
// - disabled transmitter releases pin as input
// - falling receive line wakes from sleep
// - open drain drives low only
// - double speed divides by 8, not 16, except in sync and spi modes
// - generic autobaud accepts any valid sync
// - constrained sync: pairs 32 +-6, data 0x55
// - autobaud only as asynchronous slave
// - speed field: normal, double, generic, constrained
// - multiprocessor filter drops non-address frames
// - mode field, value 3 selects spi layout
// - parity off, reserved, even, odd; checked
// - stop bits one or two, transmit only
// - width 5 to 8, reserved, nine low/high
// - spi bit order msb or lsb first
// - spi clock phase leading or trailing sample
`include "umfc_params.svh"

module umfc_ctrl
   import umfc_pkg::*;
(
   input  wire logic             clock,
   input  wire logic             srst,
   // ahb-lite slave
   input  wire logic             hsel,
   input  wire logic [31:0]      haddr,
   input  wire logic [1:0]       htrans,
   input  wire logic             hwrite,
   input  wire logic [2:0]       hsize,
   input  wire logic [31:0]      hwdata,
   input  wire logic             hready,
   output logic                  hreadyout,
   output logic                  hresp,
   output logic [31:0]           hrdata,
   // engine side
   output umfc_pkg::umfc_cfg_t   cfg,
   input  wire logic             tx_shift_busy,
   input  wire logic             tx_buf_full,
   input  wire logic             tx_bit,
   input  wire logic [8:0]       tx_char,
   output logic                  tx_parity,
   input  wire umfc_pkg::umfc_rxf_t rx_frame,
   output logic                  frame_keep,
   output logic                  rx_flush,
   output logic                  autobaud_reset,
   // sync character checker
   input  wire logic             sync_start,
   input  wire logic             pair_strobe,
   input  wire logic [7:0]       pair_samples,
   input  wire logic             sync_done,
   input  wire logic [7:0]       sync_data,
   input  wire logic             sync_baud_valid,
   output logic                  sync_ok,
   output logic                  sync_err,
   // pins and power
   input  wire logic             rxd,
   output logic                  rxd_owned,
   output logic                  txd_o,
   output logic                  txd_oe,
   output logic                  driver_enable_pin,
   input  wire logic             sleeping,
   output logic                  wake
);
   import umfc_pkg::*;

   // ************************************************************
   // register bus slave
   // ************************************************************
   logic [7:0]  line_q, rxtx_q, frame_q, spi_q;
   logic        wr_pend_q;
   logic [7:0]  wr_idx_q;
   logic [7:0]  rd_val;
   logic [7:0]  status;
   logic [7:0]  acc_idx;
   logic        acc;
   logic        rx_on_q, tx_on_q, tx_active_q;
   logic        framing_error_flag_q, ovf_q, parity_error_flag_q, sync_err_q;
   logic        spi_on;

   assign acc       = hsel & hready & htrans[1];
   assign acc_idx   = haddr[`UMFC_ADDR_W+1:2];
   assign hreadyout = 1'b1; // every access finishes with no wait state
   assign hresp     = 1'b0;
   assign spi_on    = umfc_cm_t'(frame_q[`UMFC_B_COMMUNICATION_MODE_HI:`UMFC_B_COMMUNICATION_MODE_LO]) == UMFC_CM_SPI;

   // read value chosen in the address phase; unmapped reads return zero
   always_comb begin
      if (acc_idx == `UMFC_IDX_STATUS) begin
         rd_val = status;
      end else if (acc_idx == `UMFC_IDX_LINE_CTRL) begin
         rd_val = line_q;
      end else if (acc_idx == `UMFC_IDX_RX_TX_CTRL) begin
         rd_val = rxtx_q;
      end else if (acc_idx == `UMFC_IDX_FRAME_CTRL) begin
         rd_val = spi_on ? spi_q : frame_q;
      end else begin
         rd_val = 8'h00;
      end
   end

   // read data is registered so it stands through the data phase
   always_ff @(posedge clock) begin
      if (srst) begin
         hrdata <= 32'h0;
      end else if (acc && !hwrite) begin
         hrdata <= {24'h0, rd_val};
      end
   end

   // write address held from address phase to data phase
   always_ff @(posedge clock) begin
      if (srst) begin
         wr_pend_q <= 1'b0;
         wr_idx_q  <= 8'h00;
      end else begin
         wr_pend_q <= acc & hwrite;
         wr_idx_q  <= acc_idx;
      end
   end

   // control registers; frame register layout follows the mode written
   always_ff @(posedge clock) begin
      if (srst) begin
         line_q  <= `UMFC_RST_LINE;
         rxtx_q  <= `UMFC_RST_RX_TX;
         frame_q <= `UMFC_RST_FRAME;
         spi_q   <= `UMFC_RST_SPI;
      end else if (wr_pend_q) begin
         if (wr_idx_q == `UMFC_IDX_LINE_CTRL) begin
            line_q <= {6'h0, hwdata[1:0]};
         end else if (wr_idx_q == `UMFC_IDX_RX_TX_CTRL) begin
            rxtx_q <= hwdata[7:0] & 8'hdf;
         end else if (wr_idx_q == `UMFC_IDX_FRAME_CTRL) begin
            if (umfc_cm_t'(hwdata[7:6]) == UMFC_CM_SPI) begin
               spi_q   <= hwdata[7:0] & 8'hc6;
               frame_q <= {hwdata[7:6], frame_q[5:0]};
            end else begin
               frame_q <= hwdata[7:0];
               spi_q   <= {hwdata[7:6], spi_q[5:0]};
            end
         end
      end
   end

   // ************************************************************
   // decoded configuration
   // ************************************************************
   umfc_ld_t  ld_mode;
   umfc_rxm_t rx_mode;
   umfc_cm_t  communication_mode;
   logic      od_sel, sfd_on, multiprocessor_filter_on, async_slave;

   assign ld_mode     = umfc_ld_t'(line_q[1:0]);
   assign rx_mode     = umfc_rxm_t'(rxtx_q[`UMFC_B_RECEIVE_SPEED_MODE_HI:`UMFC_B_RECEIVE_SPEED_MODE_LO]);
   assign communication_mode       = umfc_cm_t'(frame_q[`UMFC_B_COMMUNICATION_MODE_HI:`UMFC_B_COMMUNICATION_MODE_LO]);
   assign od_sel      = rxtx_q[`UMFC_B_OD_SEL];
   assign sfd_on      = rxtx_q[`UMFC_B_SFD_ON];
   assign multiprocessor_filter_on     = rxtx_q[`UMFC_B_MULTIPROCESSOR_FILTER];
   assign async_slave = communication_mode == UMFC_CM_ASYNC;
   assign rx_on_q     = rxtx_q[`UMFC_B_RX_ON];
   assign tx_on_q     = rxtx_q[`UMFC_B_TX_ON];

   // setup for the engines; reserved widths fall back to eight bits
   always_comb begin
      cfg.mode       = communication_mode;
      cfg.parity     = spi_on ? UMFC_PAR_OFF : umfc_par_t'(frame_q[5:4]);
      cfg.stop_bits  = (!spi_on && frame_q[`UMFC_B_STOP]) ? 2'd2 : 2'd1;
      cfg.nine_low_first = 1'b0;
      case (frame_q[2:0])
         3'h0: cfg.data_bits = 4'd5;
         3'h1: cfg.data_bits = 4'd6;
         3'h2: cfg.data_bits = 4'd7;
         3'h6: begin
            cfg.data_bits = 4'd9;
            cfg.nine_low_first = 1'b1;
         end
         3'h7: cfg.data_bits = 4'd9;
         default: cfg.data_bits = 4'd8;
      endcase
      if (spi_on) begin
         cfg.data_bits = 4'd8;
         cfg.nine_low_first = 1'b0;
      end
      cfg.lsb_first       = spi_on & spi_q[`UMFC_B_ORDER];
      cfg.sample_trailing = spi_on & spi_q[`UMFC_B_PHASE];
      // double speed except in sync and spi modes
      cfg.baud_div = (rx_mode == UMFC_RX_DOUBLE && communication_mode != UMFC_CM_SYNC && !spi_on)
                     ? `UMFC_DIV_DOUBLE : `UMFC_DIV_NORMAL;
      cfg.rx_enabled = rx_on_q;
      cfg.tx_enabled = tx_active_q;
   end

   assign rxd_owned = rx_on_q;

   // ************************************************************
   // receiver enable effects
   // ************************************************************
   logic rx_on_d1_q;
   logic rx_par_bad, frame_keep_d;
   always_ff @(posedge clock) begin
      if (srst) begin
         rx_on_d1_q     <= 1'b0;
         rx_flush       <= 1'b0;
         autobaud_reset <= 1'b0;
      end else begin
         rx_on_d1_q     <= rx_on_q;
         rx_flush       <= rx_on_d1_q & ~rx_on_q;
         autobaud_reset <= rx_on_d1_q & ~rx_on_q & rx_mode[1];
      end
   end

   // error flags; a disabled receiver holds them clear
   always_ff @(posedge clock) begin
      if (srst || !rx_on_q) begin
         framing_error_flag_q <= 1'b0;
         ovf_q  <= 1'b0;
         parity_error_flag_q <= 1'b0;
      end else if (rx_frame.done && frame_keep_d) begin
         framing_error_flag_q <= ~rx_frame.stop_ok;
         ovf_q  <= rx_frame.overrun;
         parity_error_flag_q <= rx_par_bad;
      end
   end

   // parity: even makes the ones count even, odd makes it odd
   logic [8:0] tx_mask, rx_mask;
   assign tx_mask = tx_char & ((9'h1 << cfg.data_bits) - 9'h1);
   assign rx_mask = rx_frame.data & ((9'h1 << cfg.data_bits) - 9'h1);
   assign tx_parity  = (^tx_mask) ^ cfg.parity[0];
   assign rx_par_bad = cfg.parity[1] & ((^rx_mask) ^ cfg.parity[0] ^ rx_frame.parity_bit);
   assign frame_keep_d = !multiprocessor_filter_on || rx_frame.is_address;

   // frame acceptance strobe for the receive buffer
   always_ff @(posedge clock) begin
      if (srst) begin
         frame_keep <= 1'b0;
      end else begin
         frame_keep <= rx_frame.done & rx_on_q & frame_keep_d;
      end
   end

   // ************************************************************
   // sync character checks
   // ************************************************************
   logic pair_bad_q, ab_mode;
   assign ab_mode = rx_mode[1] & async_slave & rx_on_q;

   // a pair outside the window spoils the whole sync character
   always_ff @(posedge clock) begin
      if (srst) begin
         pair_bad_q <= 1'b0;
      end else if (pair_strobe &&
                   (pair_samples > `UMFC_PAIR_NOM + `UMFC_PAIR_TOL ||
                    pair_samples < `UMFC_PAIR_NOM - `UMFC_PAIR_TOL)) begin
         pair_bad_q <= 1'b1;
      end else if (autobaud_reset || sync_start) begin
         pair_bad_q <= 1'b0;
      end
   end

   // verdict one cycle after the character is complete
   always_ff @(posedge clock) begin
      if (srst) begin
         sync_ok  <= 1'b0;
         sync_err <= 1'b0;
      end else if (sync_done && ab_mode) begin
         if (rx_mode == UMFC_RX_CONAB) begin
            sync_ok  <= sync_baud_valid & ~pair_bad_q & (sync_data == `UMFC_SYNC_CHAR);
            sync_err <= ~sync_baud_valid | pair_bad_q | (sync_data != `UMFC_SYNC_CHAR);
         end else begin
            sync_ok  <= sync_baud_valid;
            sync_err <= ~sync_baud_valid;
         end
      end else begin
         sync_ok  <= 1'b0;
         sync_err <= 1'b0;
      end
   end

   // sticky view for status; autobaud reset clears it
   always_ff @(posedge clock) begin
      if (srst) begin
         sync_err_q <= 1'b0;
      end else if (sync_err) begin
         sync_err_q <= 1'b1;
      end else if (autobaud_reset || sync_start) begin
         sync_err_q <= 1'b0;
      end
   end

   // ************************************************************
   // transmitter and pins
   // ************************************************************
   // disable waits for pending data so no frame is cut short
   always_ff @(posedge clock) begin
      if (srst) begin
         tx_active_q <= 1'b0;
      end else if (tx_on_q) begin
         tx_active_q <= 1'b1;
      end else if (!tx_shift_busy && !tx_buf_full) begin
         tx_active_q <= 1'b0;
      end
   end

   // pin drive; released and input once the transmitter is off
   always_ff @(posedge clock) begin
      if (srst) begin
         txd_o             <= 1'b1;
         txd_oe            <= 1'b0;
         driver_enable_pin <= 1'b0;
      end else begin
         txd_o <= od_sel ? 1'b0 : tx_bit;
         if (!tx_active_q) begin
            txd_oe <= 1'b0;
         end else if (od_sel) begin
            txd_oe <= ~tx_bit;
         end else if (ld_mode == UMFC_LD_INT) begin
            txd_oe <= tx_shift_busy;
         end else begin
            txd_oe <= 1'b1;
         end
         driver_enable_pin <= (ld_mode == UMFC_LD_EXT) & tx_active_q & tx_shift_busy;
      end
   end

   // start frame wake from sleep
   logic rxd_q;
   always_ff @(posedge clock) begin
      if (srst) begin
         rxd_q <= 1'b1;
         wake  <= 1'b0;
      end else begin
         rxd_q <= rxd;
         wake  <= sfd_on & rx_on_q & sleeping & rxd_q & ~rxd;
      end
   end

   assign status = {2'b00, sync_err_q, tx_active_q, 1'b0, framing_error_flag_q, ovf_q, parity_error_flag_q};

   // ************************************************************
   // assertions
   // ************************************************************
   property p_tx_hold;
      @(posedge clock) disable iff (srst)
      tx_active_q && (tx_shift_busy || tx_buf_full) |=> tx_active_q;
   endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("transmitter stopped early");

   property p_tx_release;
      @(posedge clock) disable iff (srst)
      !tx_active_q |=> !txd_oe;
   endproperty
   a_tx_release: assert property (p_tx_release) else $error("pin driven while off");

   sequence s_rx_off;
      rx_on_q ##1 !rx_on_q;
   endsequence
   property p_flush;
      @(posedge clock) disable iff (srst)
      s_rx_off |=> rx_flush && status[2:0] == 3'h0;
   endproperty
   a_flush: assert property (p_flush) else $error("receiver off did not flush");

   property p_abrst;
      @(posedge clock) disable iff (srst)
      s_rx_off ##0 rx_mode[1] |=> autobaud_reset;
   endproperty
   a_abrst: assert property (p_abrst) else $error("autobaud not reset");

   property p_wake;
      @(posedge clock) disable iff (srst)
      sfd_on && rx_on_q && sleeping && $fell(rxd) |=> wake;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake on start edge");

   property p_od;
      @(posedge clock) disable iff (srst)
      od_sel ##1 txd_oe |-> !txd_o;
   endproperty
   a_od: assert property (p_od) else $error("open drain drove high");

   property p_lin_char;
      @(posedge clock) disable iff (srst)
      sync_done && ab_mode && rx_mode == UMFC_RX_CONAB && sync_data != `UMFC_SYNC_CHAR
      |=> !sync_ok && sync_err;
   endproperty
   a_lin_char: assert property (p_lin_char) else $error("bad sync accepted");

   property p_div;
      @(posedge clock) disable iff (srst)
      rx_mode == UMFC_RX_DOUBLE && communication_mode == UMFC_CM_ASYNC |-> cfg.baud_div == 5'd8;
   endproperty
   a_div: assert property (p_div) else $error("double speed divisor wrong");

   property p_multiprocessor_filter;
      @(posedge clock) disable iff (srst)
      rx_frame.done && multiprocessor_filter_on && !rx_frame.is_address |=> !frame_keep;
   endproperty
   a_multiprocessor_filter: assert property (p_multiprocessor_filter) else $error("data frame kept under filter");

endmodule : umfc_ctrl

// ### verif/umfc_node_model.sv
// model of the shift engines and the remote node facing the control block
module umfc_node_model
   import umfc_pkg::*;
(
   input  wire logic           clock,
   input  wire logic           srst,
   input  wire logic           tx_go,
   input  wire logic [7:0]     tx_len,
   input  wire logic           rx_go,
   input  wire logic           rx_addr,
   input  wire logic [8:0]     rx_data,
   input  wire logic           rx_par,
   output logic                tx_shift_busy,
   output logic                tx_buf_full,
   output umfc_pkg::umfc_rxf_t rx_frame,
   output logic                rxd
);
   timeunit 1ns;
   timeprecision 1ps;
   import umfc_pkg::*;
   logic [7:0] busy_q;
   logic [1:0] buf_q;
   logic [2:0] rx_q;
   // **********
   // transmit side
   // **********
   // buffer hands over early, shifter runs tx_len cycles after the go pulse
   always_ff @(posedge clock) begin
      if (srst) begin
         busy_q <= 8'h00;
         buf_q  <= 2'h0;
      end else if (tx_go) begin
         busy_q <= tx_len;
         buf_q  <= 2'h3;
      end else begin
         busy_q <= (busy_q != 8'h00) ? busy_q - 8'h01 : 8'h00;
         buf_q  <= (buf_q != 2'h0) ? buf_q - 2'h1 : 2'h0;
      end
   end
   assign tx_shift_busy = (busy_q != 8'h00);
   assign tx_buf_full   = (buf_q != 2'h0);
   // **********
   // receive side
   // **********
   // line low for the whole frame so the start edge is seen; done pulses once
   always_ff @(posedge clock) begin
      if (srst) begin
         rx_q <= 3'h0;
      end else if (rx_go) begin
         rx_q <= 3'h5;
      end else if (rx_q != 3'h0) begin
         rx_q <= rx_q - 3'h1;
      end
   end
   assign rxd      = (rx_q == 3'h0);
   assign rx_frame = {rx_q == 3'h1, rx_data, rx_par, 1'b1, rx_addr, 1'b0};
endmodule : umfc_node_model

// ### verif/usart_mode_and_frame_control_tb.sv
// self-checking bench of the serial mode and frame control block
`include "umfc_params.svh"
module usart_mode_and_frame_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import umfc_pkg::*;
   logic        clock, srst, hsel, hwrite, hreadyout, hresp, tx_parity, clr;
   logic        frame_keep, rx_flush, autobaud_reset, sync_ok, sync_err, rxd_owned;
   logic        txd_o, txd_oe, driver_enable_pin, wake, tx_shift_busy, tx_buf_full;
   logic        rxd, tx_bit, sleeping, sync_start, pair_strobe, sync_done;
   logic        sync_baud_valid, tx_go, rx_go, rx_addr, rx_par;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [7:0]  pair_samples, sync_data, tx_len;
   logic [8:0]  tx_char, rx_data;
   logic [6:0]  seen;
   umfc_cfg_t   cfg;
   umfc_rxf_t   rx_frame;
   int          fail_count, n_checks, cyc_count;
   localparam logic [7:0] i_st = `UMFC_IDX_STATUS;
   localparam logic [7:0] i_ld = `UMFC_IDX_LINE_CTRL;
   localparam logic [7:0] i_rt = `UMFC_IDX_RX_TX_CTRL;
   localparam logic [7:0] i_fc = `UMFC_IDX_FRAME_CTRL;

   umfc_ctrl dut (.clock, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .cfg, .tx_shift_busy, .tx_buf_full,
      .tx_bit, .tx_char, .tx_parity, .rx_frame, .frame_keep, .rx_flush, .autobaud_reset,
      .sync_start, .pair_strobe, .pair_samples, .sync_done, .sync_data, .sync_baud_valid,
      .sync_ok, .sync_err, .rxd, .rxd_owned, .txd_o, .txd_oe, .driver_enable_pin,
      .sleeping, .wake);
   umfc_node_model node (.clock, .srst, .tx_go, .tx_len, .rx_go, .rx_addr, .rx_data,
      .rx_par, .tx_shift_busy, .tx_buf_full, .rx_frame, .rxd);

   // **********
   // clock, pulse catcher, watchdog
   // **********
   always #10 clock = ~clock;
   // pulses are one cycle wide, so they are gathered here between checks
   always @(posedge clock) begin
      seen <= clr ? 7'h00 : seen | {driver_enable_pin, wake, sync_err, sync_ok,
                                    frame_keep, autobaud_reset, rx_flush};
      cyc_count++;
      if (cyc_count == 20000) begin
         fail_count++;
         end_sim();
      end
   end

   // **********
   // shared tasks
   // **********
   task automatic end_sim();
      $display("checks %0d errors %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : end_sim
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      n_checks++;
      if (s !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask : cyc
   // one single transfer; the slave may stretch either phase
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      htrans <= 2'h2;
      hwrite <= w;
      haddr  <= {22'h0, a, 2'h0};
      do @(posedge clock); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clock); while (hreadyout !== 1'b1);
      q = hrdata;
      chk("hresp", 32'h0, 32'(hresp));
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, {24'h0, d});
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      bus(1'b0, a, 32'h0);
      chk("register", {24'h0, e}, q);
   endtask : rd
   task automatic clear();
      clr <= 1'b1;
      @(posedge clock);
      clr <= 1'b0;
   endtask : clear
   task automatic look(input logic [6:0] m, input logic [6:0] e);
      cyc(8);
      chk("pulses", 32'(e), 32'(seen & m));
   endtask : look
   task automatic rxf(input logic a, input logic p, input logic [6:0] m, e);
      clear();
      rx_addr <= a;
      rx_data <= 9'h001;
      rx_par  <= p;
      rx_go   <= 1'b1;
      @(posedge clock);
      rx_go <= 1'b0;
      look(m, e);
   endtask : rxf
   task automatic txgo();
      tx_len <= 8'h14;
      tx_go  <= 1'b1;
      @(posedge clock);
      tx_go <= 1'b0;
   endtask : txgo
   task automatic speed(input logic [7:0] v, input logic [4:0] dv);
      wr(i_rt, v | 8'h20);
      rd(i_rt, v);
      chk("baud_div", 32'(dv), 32'(cfg.baud_div));
      chk("rxd_owned", 32'h1, 32'(rxd_owned));
      chk("rx_enabled", 32'h1, 32'(cfg.rx_enabled));
   endtask : speed
   task automatic syn(input logic [7:0] p, d, input logic v, input logic [6:0] e);
      clear();
      sync_start <= 1'b1;
      @(posedge clock);
      sync_start   <= 1'b0;
      pair_samples <= p;
      pair_strobe  <= 1'b1;
      cyc(4);
      pair_strobe     <= 1'b0;
      sync_done       <= 1'b1;
      sync_data       <= d;
      sync_baud_valid <= v;
      @(posedge clock);
      sync_done <= 1'b0;
      look(7'h18, e);
   endtask : syn

   // **********
   // scenarios
   // **********
   // reset values, unmapped place, speed decode
   task automatic t_regs();
      rd(i_rt, 8'h00);
      rd(i_fc, 8'h03);
      rd(i_ld, 8'h00);
      wr(8'h20, 8'hff);
      rd(8'h20, 8'h00);
      chk("data_bits", 32'h8, 32'(cfg.data_bits));
      chk("rxd_owned", 32'h0, 32'(rxd_owned));
      speed(8'h80, 5'h10);
      speed(8'h82, 5'h08);
      wr(i_rt, 8'h00);
   endtask : t_regs
   // every legal width, stop setting alternating one and two, then both parities
   task automatic t_frame();
      logic [2:0] code [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
      logic [3:0] nb   [6] = '{4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'h9};
      for (int i = 0; i < 6; i++) begin
         wr(i_fc, {4'h0, i[0], code[i]});
         rd(i_fc, {4'h0, i[0], code[i]});
         chk("data_bits", 32'(nb[i]), 32'(cfg.data_bits));
         chk("stop_bits", 32'(i[0]) + 32'h1, 32'(cfg.stop_bits));
         chk("nine_low", 32'(code[i] == 3'h6), 32'(cfg.nine_low_first));
      end
      tx_char <= 9'h00b;
      wr(i_fc, 8'h23);
      cyc(1);
      chk("tx_parity", 32'h1, 32'(tx_parity));
      wr(i_fc, 8'h33);
      cyc(1);
      chk("tx_parity", 32'h0, 32'(tx_parity));
      // the whole nine-bit character is presented at once, ninth bit in place
      tx_char <= 9'h10b;
      wr(i_fc, 8'h27);
      cyc(1);
      chk("tx_parity", 32'h0, 32'(tx_parity));
      wr(i_fc, 8'hf6);
      rd(i_fc, 8'hc6);
      chk("mode", 32'h3, 32'(cfg.mode));
      chk("lsb_first", 32'h1, 32'(cfg.lsb_first));
      chk("trailing", 32'h1, 32'(cfg.sample_trailing));
      wr(i_fc, 8'hc0);
      cyc(1);
      chk("lsb_first", 32'h0, 32'(cfg.lsb_first));
      chk("trailing", 32'h0, 32'(cfg.sample_trailing));
   endtask : t_frame
   // address filter, parity error, flush on receiver off
   task automatic t_rx();
      wr(i_fc, 8'h23);
      wr(i_rt, 8'h81);
      rxf(1'b0, 1'b1, 7'h04, 7'h00);
      rxf(1'b1, 1'b0, 7'h04, 7'h04);
      rd(i_st, 8'h01);
      clear();
      wr(i_rt, 8'h00);
      look(7'h03, 7'h01);
      rd(i_st, 8'h00);
      wr(i_rt, 8'h84);
      clear();
      wr(i_rt, 8'h04);
      look(7'h03, 7'h03);
      wr(i_rt, 8'h90);
      sleeping <= 1'b1;
      rxf(1'b0, 1'b1, 7'h20, 7'h20);
      wr(i_rt, 8'h80);
      rxf(1'b0, 1'b1, 7'h20, 7'h00);
      sleeping <= 1'b0;
   endtask : t_rx
   // drain after disable, external driver, open drain
   task automatic t_tx();
      wr(i_ld, 8'h01);
      wr(i_rt, 8'h40);
      txgo();
      cyc(3);
      chk("driver_en", 32'h1, 32'(driver_enable_pin));
      wr(i_rt, 8'h00);
      chk("tx_enabled", 32'h1, 32'(cfg.tx_enabled));
      chk("txd_oe", 32'h1, 32'(txd_oe));
      while (tx_shift_busy === 1'b1) @(posedge clock);
      cyc(3);
      chk("tx_enabled", 32'h0, 32'(cfg.tx_enabled));
      chk("txd_oe", 32'h0, 32'(txd_oe));
      chk("driver_en", 32'h0, 32'(driver_enable_pin));
      wr(i_ld, 8'h02);
      wr(i_rt, 8'h40);
      txgo();
      cyc(2);
      chk("txd_oe", 32'h1, 32'(txd_oe));
      chk("driver_en", 32'h0, 32'(driver_enable_pin));
      while (tx_shift_busy === 1'b1) @(posedge clock);
      cyc(2);
      chk("txd_oe", 32'h0, 32'(txd_oe));
      wr(i_ld, 8'h00);
      wr(i_rt, 8'h48);
      txgo();
      tx_bit <= 1'b1;
      cyc(3);
      chk("txd_oe", 32'h0, 32'(txd_oe));
      tx_bit <= 1'b0;
      cyc(3);
      chk("txd_drive", 32'h1, {31'h0, txd_oe & ~txd_o});
      wr(i_rt, 8'h00);
   endtask : t_tx
   // sync character checks in both auto-baud modes
   task automatic t_sync();
      wr(i_fc, 8'h03);
      wr(i_rt, 8'h86);
      syn(8'h1a, 8'h55, 1'b1, 7'h08);
      syn(8'h26, 8'h55, 1'b1, 7'h08);
      syn(8'h19, 8'h55, 1'b1, 7'h10);
      syn(8'h27, 8'h55, 1'b1, 7'h10);
      syn(8'h20, 8'h54, 1'b1, 7'h10);
      wr(i_rt, 8'h84);
      syn(8'h32, 8'h12, 1'b1, 7'h08);
      syn(8'h20, 8'h55, 1'b0, 7'h10);
      rd(i_st, 8'h20);
      wr(i_fc, 8'hc3);
      syn(8'h20, 8'h55, 1'b1, 7'h00);
      wr(i_rt, 8'h00);
   endtask : t_sync

   // **********
   // main sequence
   // **********
   initial begin
      {clock, hsel, hwrite, tx_bit, sleeping, sync_start, pair_strobe, sync_done} = '0;
      {sync_baud_valid, tx_go, rx_go, rx_addr, rx_par, clr} = '0;
      {haddr, hwdata, htrans, pair_samples, sync_data, tx_len, tx_char, rx_data} = '0;
      {fail_count, n_checks, cyc_count} = '0;
      hsize = 3'h2;
      srst  = 1'b1;
      repeat (12) @(posedge clock);
      srst <= 1'b0;
      hsel <= 1'b1;
      t_regs();
      t_frame();
      t_rx();
      t_tx();
      t_sync();
      end_sim();
   end
endmodule : usart_mode_and_frame_control_tb
